// file: rtl/jtp_pkg.sv
// Constants, state codes and instruction codes of the test access port controller.
// Assumes the controller and its bench use these names through jtp_pkg::name.
//
// How it works
// - State advances on rising test clock edges.
// - Low test reset forces and holds reset state.
// - Reset state loads identification instruction.
// - Five high mode samples reach reset state.
// - Power-on reset also forces reset state.
// - Data in sampled rising, routed to chain.
// - Data out changes on falling clock edge.
// - Data out driven only while shifting.
// - Stopped test clock keeps state and data.
// - Unimplemented instruction codes decode as bypass.
// - External and internal test leave boundary chain untouched.
// - Active instruction selects the single data chain.
// - State picks instruction or data chain path.
// - State machine drives capture, shift, update.
// - Pins start as port; committed writes change.
// - Instruction chain is four bits wide.
// - Update copies shift contents into parallel stage.

package jtp_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int IR_WIDTH   = 4;
  localparam int ID_WIDTH   = 32;
  localparam int BSR_WIDTH  = 8;
  localparam int PIN_COUNT  = 5;

  // ---------------------------------------------------------------
  // Instruction codes and reset values
  // ---------------------------------------------------------------
  localparam logic [IR_WIDTH-1:0]  IR_CODE_EXTEST  = 4'h0;
  localparam logic [IR_WIDTH-1:0]  IR_CODE_INTEST  = 4'h1;
  localparam logic [IR_WIDTH-1:0]  IR_CODE_SAMPLE  = 4'h2;
  localparam logic [IR_WIDTH-1:0]  IR_CODE_IDCODE  = 4'he;
  localparam logic [IR_WIDTH-1:0]  IR_CODE_BYPASS  = 4'hf;
  localparam logic [IR_WIDTH-1:0]  IR_CAPTURE_VAL  = 4'h1;
  // Identification word: the value is arbitrary; bit 0 must stay set.
  localparam logic [ID_WIDTH-1:0]  ID_VALUE        = 32'h0000_1001;
  localparam logic [BSR_WIDTH-1:0] BSR_RESET_VAL   = 8'h00;
  localparam logic [PIN_COUNT-1:0] AFSEL_RESET_VAL = 5'h1f;

  // ---------------------------------------------------------------
  // Controller states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_EXIT2_DR   = 4'b0000,
    ST_EXIT1_DR   = 4'b0001,
    ST_SHIFT_DR   = 4'b0010,
    ST_PAUSE_DR   = 4'b0011,
    ST_SELECT_IR  = 4'b0100,
    ST_UPDATE_DR  = 4'b0101,
    ST_CAPTURE_DR = 4'b0110,
    ST_SELECT_DR  = 4'b0111,
    ST_EXIT2_IR   = 4'b1000,
    ST_EXIT1_IR   = 4'b1001,
    ST_SHIFT_IR   = 4'b1010,
    ST_PAUSE_IR   = 4'b1011,
    ST_RUN_IDLE   = 4'b1100,
    ST_UPDATE_IR  = 4'b1101,
    ST_CAPTURE_IR = 4'b1110,
    ST_TEST_RESET = 4'b1111
  } jtp_state_type;

  // ---------------------------------------------------------------
  // Decoded instructions
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_BYPASS = 3'b000,
    OP_IDCODE = 3'b001,
    OP_SAMPLE = 3'b010,
    OP_EXTEST = 3'b011,
    OP_INTEST = 3'b100
  } jtp_op_type;

endpackage

// file: rtl/jtp_sync.sv
// Two-stage level synchroniser for a group of independent level signals.
// Assumes each bit is a slowly changing level; words are not kept coherent.

`timescale 1ns/1ps

module jtp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,     // Destination clock.
  input  wire logic         rst,     // Asynchronous reset, active high.
  input  wire logic [W-1:0] d_in,    // Level from another domain.
  output logic      [W-1:0] q_out    // Level in the destination domain.
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } jtp_sync_type;

  jtp_sync_type s_reg;
  jtp_sync_type s_next;

  always_comb
  begin
    s_next      = s_reg;
    s_next.meta = d_in;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign q_out = s_reg.sync;

endmodule // jtp_sync

// file: rtl/jtp_tap_controller.sv
// Test access port controller: state machine, instruction chain, data chains, serial out.
// Assumes TCK, TMS and TDI come from a probe and the system side runs on CLOCK.

`timescale 1ns/1ps

module jtp_tap_controller #(
  parameter logic [jtp_pkg::IR_WIDTH-1:0] CODE_EXTEST = jtp_pkg::IR_CODE_EXTEST,
  parameter logic [jtp_pkg::IR_WIDTH-1:0] CODE_INTEST = jtp_pkg::IR_CODE_INTEST,
  parameter logic [jtp_pkg::IR_WIDTH-1:0] CODE_SAMPLE = jtp_pkg::IR_CODE_SAMPLE,
  parameter logic [jtp_pkg::IR_WIDTH-1:0] CODE_IDCODE = jtp_pkg::IR_CODE_IDCODE
) (
  input  wire logic                           CLOCK,            // System clock.
  input  wire logic                           RST,              // Power-on reset, high.
  input  wire logic                           TCK,              // Test clock.
  input  wire logic                           TRST_N,           // Test reset, low.
  input  wire logic                           TMS,              // Mode select.
  input  wire logic                           TDI,              // Serial data in.
  output logic                                TDO,              // Serial data out.
  output logic                                TDO_OE,           // Drive enable of TDO.
  input  wire logic [jtp_pkg::BSR_WIDTH-1:0]  BSR_CAPTURE_IN,   // Pin levels to capture.
  output logic      [jtp_pkg::BSR_WIDTH-1:0]  BSR_PARALLEL_OUT, // Boundary update stage.
  output logic                                EXTEST_ACTIVE,    // On CLOCK, level.
  output logic                                INTEST_ACTIVE,    // On CLOCK, level.
  input  wire logic                           AFSEL_WRITE,      // Select write strobe.
  input  wire logic [jtp_pkg::PIN_COUNT-1:0]  AFSEL_WDATA,      // Select write data.
  input  wire logic [jtp_pkg::PIN_COUNT-1:0]  AFSEL_COMMIT,     // Per-pin commit allow.
  output logic      [jtp_pkg::PIN_COUNT-1:0]  PIN_ALT_FUNC_SEL  // 1 keeps port function.
);

  // ---------------------------------------------------------------
  // Types and functions
  // ---------------------------------------------------------------
  typedef struct packed {
    jtp_pkg::jtp_state_type                st;
    logic [jtp_pkg::IR_WIDTH-1:0]          ir_shift;
    logic [jtp_pkg::IR_WIDTH-1:0]          ir_par;
    logic                                  bypass;
    logic [jtp_pkg::ID_WIDTH-1:0]          id_shift;
    logic [jtp_pkg::BSR_WIDTH-1:0]         bsr_shift;
    logic [jtp_pkg::BSR_WIDTH-1:0]         bsr_par;
    logic [1:0]                            mode;
  } jtp_tap_type;

  typedef struct packed {
    logic tdo;
    logic oe;
  } jtp_out_type;

  typedef struct packed {
    logic [jtp_pkg::PIN_COUNT-1:0] afsel;
  } jtp_sys_type;

  function automatic jtp_pkg::jtp_state_type next_state(jtp_pkg::jtp_state_type s, logic m);
    jtp_pkg::jtp_state_type n;
    n = s;
    unique case (s)
      jtp_pkg::ST_TEST_RESET: n = m ? jtp_pkg::ST_TEST_RESET : jtp_pkg::ST_RUN_IDLE;
      jtp_pkg::ST_RUN_IDLE:   n = m ? jtp_pkg::ST_SELECT_DR  : jtp_pkg::ST_RUN_IDLE;
      jtp_pkg::ST_SELECT_DR:  n = m ? jtp_pkg::ST_SELECT_IR  : jtp_pkg::ST_CAPTURE_DR;
      jtp_pkg::ST_CAPTURE_DR: n = m ? jtp_pkg::ST_EXIT1_DR   : jtp_pkg::ST_SHIFT_DR;
      jtp_pkg::ST_SHIFT_DR:   n = m ? jtp_pkg::ST_EXIT1_DR   : jtp_pkg::ST_SHIFT_DR;
      jtp_pkg::ST_EXIT1_DR:   n = m ? jtp_pkg::ST_UPDATE_DR  : jtp_pkg::ST_PAUSE_DR;
      jtp_pkg::ST_PAUSE_DR:   n = m ? jtp_pkg::ST_EXIT2_DR   : jtp_pkg::ST_PAUSE_DR;
      jtp_pkg::ST_EXIT2_DR:   n = m ? jtp_pkg::ST_UPDATE_DR  : jtp_pkg::ST_SHIFT_DR;
      jtp_pkg::ST_UPDATE_DR:  n = m ? jtp_pkg::ST_SELECT_DR  : jtp_pkg::ST_RUN_IDLE;
      jtp_pkg::ST_SELECT_IR:  n = m ? jtp_pkg::ST_TEST_RESET : jtp_pkg::ST_CAPTURE_IR;
      jtp_pkg::ST_CAPTURE_IR: n = m ? jtp_pkg::ST_EXIT1_IR   : jtp_pkg::ST_SHIFT_IR;
      jtp_pkg::ST_SHIFT_IR:   n = m ? jtp_pkg::ST_EXIT1_IR   : jtp_pkg::ST_SHIFT_IR;
      jtp_pkg::ST_EXIT1_IR:   n = m ? jtp_pkg::ST_UPDATE_IR  : jtp_pkg::ST_PAUSE_IR;
      jtp_pkg::ST_PAUSE_IR:   n = m ? jtp_pkg::ST_EXIT2_IR   : jtp_pkg::ST_PAUSE_IR;
      jtp_pkg::ST_EXIT2_IR:   n = m ? jtp_pkg::ST_UPDATE_IR  : jtp_pkg::ST_SHIFT_IR;
      jtp_pkg::ST_UPDATE_IR:  n = m ? jtp_pkg::ST_SELECT_DR  : jtp_pkg::ST_RUN_IDLE;
    endcase
    return n;
  endfunction

  function automatic jtp_pkg::jtp_op_type decode(logic [jtp_pkg::IR_WIDTH-1:0] code);
    jtp_pkg::jtp_op_type op;
    op = jtp_pkg::OP_BYPASS;
    if (code == CODE_IDCODE)
      op = jtp_pkg::OP_IDCODE;
    else if (code == CODE_SAMPLE)
      op = jtp_pkg::OP_SAMPLE;
    else if (code == CODE_EXTEST)
      op = jtp_pkg::OP_EXTEST;
    else if (code == CODE_INTEST)
      op = jtp_pkg::OP_INTEST;
    return op;
  endfunction

  // ---------------------------------------------------------------
  // Test clock domain
  // ---------------------------------------------------------------
  logic                           tap_rst;
  logic [jtp_pkg::BSR_WIDTH-1:0]  capture_sync;
  jtp_tap_type                    tap_reg;
  jtp_tap_type                    tap_next;
  jtp_out_type                    out_reg;
  jtp_out_type                    out_next;
  jtp_pkg::jtp_op_type            op;
  logic                           shift_dr;
  logic                           shift_ir;
  logic                           serial_bit;

  assign tap_rst = RST | ~TRST_N;
  assign op       = decode(tap_reg.ir_par);
  assign shift_dr = (tap_reg.st == jtp_pkg::ST_SHIFT_DR);
  assign shift_ir = (tap_reg.st == jtp_pkg::ST_SHIFT_IR);

  jtp_sync #(
    .W (jtp_pkg::BSR_WIDTH)
  ) u_capture_sync (
    .clk   (TCK),
    .rst   (tap_rst),
    .d_in  (BSR_CAPTURE_IN),
    .q_out (capture_sync)
  );

  always_comb
  begin
    tap_next    = tap_reg;
    tap_next.st = next_state(tap_reg.st, TMS);
    unique case (tap_reg.st)
      jtp_pkg::ST_CAPTURE_IR:
      begin
        tap_next.ir_shift = jtp_pkg::IR_CAPTURE_VAL;
      end
      jtp_pkg::ST_SHIFT_IR:
      begin
        tap_next.ir_shift = {TDI, tap_reg.ir_shift[jtp_pkg::IR_WIDTH-1:1]};
      end
      jtp_pkg::ST_UPDATE_IR:
      begin
        tap_next.ir_par = tap_reg.ir_shift;
      end
      jtp_pkg::ST_CAPTURE_DR:
      begin
        unique case (op)
          jtp_pkg::OP_IDCODE: tap_next.id_shift  = jtp_pkg::ID_VALUE;
          jtp_pkg::OP_SAMPLE: tap_next.bsr_shift = capture_sync;
          jtp_pkg::OP_BYPASS: tap_next.bypass    = 1'b0;
          jtp_pkg::OP_EXTEST: tap_next.bypass    = 1'b0;
          jtp_pkg::OP_INTEST: tap_next.bypass    = 1'b0;
        endcase
      end
      jtp_pkg::ST_SHIFT_DR:
      begin
        unique case (op)
          jtp_pkg::OP_IDCODE:
          begin
            tap_next.id_shift = {TDI, tap_reg.id_shift[jtp_pkg::ID_WIDTH-1:1]};
          end
          jtp_pkg::OP_SAMPLE:
          begin
            tap_next.bsr_shift = {TDI, tap_reg.bsr_shift[jtp_pkg::BSR_WIDTH-1:1]};
          end
          jtp_pkg::OP_BYPASS: tap_next.bypass = TDI;
          jtp_pkg::OP_EXTEST: tap_next.bypass = TDI;
          jtp_pkg::OP_INTEST: tap_next.bypass = TDI;
        endcase
      end
      jtp_pkg::ST_UPDATE_DR:
      begin
        if (op == jtp_pkg::OP_SAMPLE)
        begin
          tap_next.bsr_par = tap_reg.bsr_shift;
        end
      end
      default:
      begin
        tap_next.bypass = tap_reg.bypass;
      end
    endcase
    if (tap_next.st == jtp_pkg::ST_TEST_RESET)
    begin
      tap_next.ir_par = CODE_IDCODE;
    end
    // Decoded test modes are registered so the system side synchronises clean levels.
    tap_next.mode = {decode(tap_next.ir_par) == jtp_pkg::OP_INTEST,
                     decode(tap_next.ir_par) == jtp_pkg::OP_EXTEST};
  end

  // State only moves on test clock edges, so a stopped clock holds everything.
  always_ff @(posedge TCK or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      tap_reg           <= '0;
      tap_reg.st        <= jtp_pkg::ST_TEST_RESET;
      tap_reg.ir_par    <= CODE_IDCODE;
      tap_reg.ir_shift  <= jtp_pkg::IR_CAPTURE_VAL;
      tap_reg.bsr_shift <= jtp_pkg::BSR_RESET_VAL;
      tap_reg.bsr_par   <= jtp_pkg::BSR_RESET_VAL;
    end
    else
    begin
      tap_reg <= tap_next;
    end
  end

  // ---------------------------------------------------------------
  // Serial output, falling edge
  // ---------------------------------------------------------------
  always_comb
  begin
    serial_bit = tap_reg.bypass;
    if (shift_ir)
    begin
      serial_bit = tap_reg.ir_shift[0];
    end
    else if (op == jtp_pkg::OP_IDCODE)
    begin
      serial_bit = tap_reg.id_shift[0];
    end
    else if (op == jtp_pkg::OP_SAMPLE)
    begin
      serial_bit = tap_reg.bsr_shift[0];
    end
    out_next     = out_reg;
    out_next.oe  = shift_dr | shift_ir;
    out_next.tdo = (shift_dr | shift_ir) ? serial_bit : out_reg.tdo;
  end

  always_ff @(negedge TCK or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      out_reg <= '0;
    end
    else
    begin
      out_reg <= out_next;
    end
  end

  assign TDO              = out_reg.tdo;
  assign TDO_OE           = out_reg.oe;
  assign BSR_PARALLEL_OUT = tap_reg.bsr_par;

  // ---------------------------------------------------------------
  // System clock domain
  // ---------------------------------------------------------------
  logic [1:0]  mode_sync;
  jtp_sys_type sys_reg;
  jtp_sys_type sys_next;

  jtp_sync #(
    .W (2)
  ) u_mode_sync (
    .clk   (CLOCK),
    .rst   (RST),
    .d_in  (tap_reg.mode),
    .q_out (mode_sync)
  );

  always_comb
  begin
    sys_next = sys_reg;
    if (AFSEL_WRITE)
    begin
      sys_next.afsel = (AFSEL_COMMIT & AFSEL_WDATA) | (~AFSEL_COMMIT & sys_reg.afsel);
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      sys_reg.afsel <= jtp_pkg::AFSEL_RESET_VAL;
    end
    else
    begin
      sys_reg <= sys_next;
    end
  end

  assign PIN_ALT_FUNC_SEL = sys_reg.afsel;
  assign EXTEST_ACTIVE    = mode_sync[0];
  assign INTEST_ACTIVE    = mode_sync[1];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence tms_five_high;
    TMS [*5];
  endsequence

  property five_high_resets;
    @(posedge TCK) disable iff (tap_rst)
      tms_five_high |=> (tap_reg.st == jtp_pkg::ST_TEST_RESET);
  endproperty

  chk_tms_five_reset: assert property (five_high_resets)
    else $error("Five high mode samples did not reach reset state.");

  chk_reset_idcode: assert property (@(posedge TCK) disable iff (tap_rst)
    (tap_reg.st == jtp_pkg::ST_TEST_RESET) |-> (tap_reg.ir_par == CODE_IDCODE))
    else $error("Reset state without identification instruction.");

  sequence ir_update_seq;
    tap_reg.st == jtp_pkg::ST_UPDATE_IR;
  endsequence

  chk_ir_update_copy: assert property (@(posedge TCK) disable iff (tap_rst)
    ir_update_seq |=> (tap_reg.ir_par == $past(tap_reg.ir_shift)) ||
                      (tap_reg.st == jtp_pkg::ST_TEST_RESET))
    else $error("Instruction update did not copy shift stage.");

  chk_ir_shift_in: assert property (@(posedge TCK) disable iff (tap_rst)
    shift_ir |=> (tap_reg.ir_shift[jtp_pkg::IR_WIDTH-1] == $past(TDI)))
    else $error("Data in not shifted into instruction chain.");

  chk_id_capture: assert property (@(posedge TCK) disable iff (tap_rst)
    (tap_reg.st == jtp_pkg::ST_CAPTURE_DR && op == jtp_pkg::OP_IDCODE)
      |=> (tap_reg.id_shift == jtp_pkg::ID_VALUE))
    else $error("Identification chain not captured.");

  chk_tdo_oe_shift: assert property (@(posedge TCK) disable iff (tap_rst)
    TDO_OE == (shift_dr || shift_ir))
    else $error("Data out driven outside a shift state.");

  chk_tdo_bypass: assert property (@(posedge TCK) disable iff (tap_rst)
    (shift_dr && op == jtp_pkg::OP_BYPASS && $past(shift_dr))
      |-> (TDO_OE && TDO == tap_reg.bypass))
    else $error("Bypass bit not presented on data out.");

  chk_extest_no_update: assert property (@(posedge TCK) disable iff (tap_rst)
    (op == jtp_pkg::OP_EXTEST || op == jtp_pkg::OP_INTEST)
      |=> $stable(tap_reg.bsr_par) && $stable(tap_reg.bsr_shift))
    else $error("Test instruction touched the boundary chain.");

  chk_afsel_commit: assert property (@(posedge CLOCK) disable iff (RST)
    (AFSEL_WRITE && AFSEL_COMMIT == '0) |=> $stable(PIN_ALT_FUNC_SEL))
    else $error("Pin function changed without commit.");

  chk_reset_holds: assert property (@(posedge TCK)
    tap_rst |-> (tap_reg.st == jtp_pkg::ST_TEST_RESET && tap_reg.ir_par == CODE_IDCODE))
    else $error("Reset did not hold the reset state.");

  chk_ir_capture: assert property (@(posedge TCK) disable iff (tap_rst)
    (tap_reg.st == jtp_pkg::ST_CAPTURE_IR) |=> (tap_reg.ir_shift == jtp_pkg::IR_CAPTURE_VAL))
    else $error("Instruction chain not captured.");

endmodule // jtp_tap_controller

// file: verif/jtp_probe_model.sv
// Behavioural boundary-scan probe that drives the test clock, mode select and data in.
// Assumes the bench resolves the data-out wire, with its pull-up, into tdo_wire.

`timescale 1ns/1ps

module jtp_probe_model (
  output logic      tck,      // Test clock, stands still between frames.
  output logic      tms,      // Mode select.
  output logic      tdi,      // Serial data in.
  input  wire logic tdo_wire  // Resolved data-out wire.
);

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // ---------------------------------------------------------------
  // One test clock period
  // ---------------------------------------------------------------
  // Inputs change while the clock is low and data out is taken at the rising edge.
  task automatic tck_bit(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #15;
    tck = 1'b1;
    q = tdo_wire;
    #15;
    tck = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Full scan of a chain from Run-Idle back to Run-Idle
  // ---------------------------------------------------------------
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = 32'h0000_0000;
    tck_bit(1'b1, 1'b1, q);
    if (ir)
    begin
      tck_bit(1'b1, 1'b1, q);
    end
    tck_bit(1'b0, 1'b1, q);
    tck_bit(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      tck_bit(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tck_bit(1'b1, 1'b1, q);
    tck_bit(1'b0, 1'b1, q);
  endtask

endmodule // jtp_probe_model

// file: verif/tb_jtp_tap_controller.sv
// Self-checking bench of the test access port controller with a probe model.
// Assumes the probe model drives the link side and the bench drives the system side.

`timescale 1ns/1ps

module tb_jtp_tap_controller;

  logic                            clock;
  logic                            rst;
  logic                            trst_n;
  logic                            tck;
  logic                            tms;
  logic                            tdi;
  logic                            tdo;
  logic                            tdo_oe;
  logic                            tdo_wire;
  logic [jtp_pkg::BSR_WIDTH-1:0]   bsr_in;
  logic [jtp_pkg::BSR_WIDTH-1:0]   bsr_out;
  logic                            ext_act;
  logic                            int_act;
  logic                            afsel_write;
  logic [jtp_pkg::PIN_COUNT-1:0]   afsel_wdata;
  logic [jtp_pkg::PIN_COUNT-1:0]   afsel_commit;
  logic [jtp_pkg::PIN_COUNT-1:0]   pin_sel;
  logic [31:0]                     d;
  logic                            q;
  int                              err_total;
  int                              cmp_count;

  // The data-out pin has a pull-up, so an undriven wire reads high.
  assign tdo_wire = tdo_oe ? tdo : 1'b1;

  jtp_tap_controller i_jtp_tap_controller (
    .CLOCK(clock), .RST(rst), .TCK(tck), .TRST_N(trst_n), .TMS(tms), .TDI(tdi),
    .TDO(tdo), .TDO_OE(tdo_oe), .BSR_CAPTURE_IN(bsr_in), .BSR_PARALLEL_OUT(bsr_out),
    .EXTEST_ACTIVE(ext_act), .INTEST_ACTIVE(int_act), .AFSEL_WRITE(afsel_write),
    .AFSEL_WDATA(afsel_wdata), .AFSEL_COMMIT(afsel_commit), .PIN_ALT_FUNC_SEL(pin_sel)
  );

  jtp_probe_model i_jtp_probe_model (
    .tck(tck), .tms(tms), .tdi(tdi), .tdo_wire(tdo_wire)
  );

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic close_out();
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic read_id(input string name);
    i_jtp_probe_model.scan(1'b0, 32, 32'h0000_0000, d);
    chk(name, jtp_pkg::ID_VALUE, d);
    chk("tdo_idle", 32'h1, tdo_wire);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_state();
    chk("oe_reset", 32'h0, tdo_oe);
    chk("bsr_reset", 32'h0, bsr_out);
    chk("pins_reset", 32'h1f, pin_sel);
    i_jtp_probe_model.tck_bit(1'b0, 1'b1, q);
    read_id("idcode_first");
  endtask

  task automatic t_sample();
    i_jtp_probe_model.scan(1'b1, 4, 32'(jtp_pkg::IR_CODE_SAMPLE), d);
    chk("ir_capture", 32'(jtp_pkg::IR_CAPTURE_VAL), d[3:0]);
    i_jtp_probe_model.scan(1'b0, 8, 32'h3c, d);
    chk("bsr_capture", 32'ha5, d[7:0]);
    chk("bsr_update", 32'h3c, bsr_out);
    #2000;
    chk("bsr_stopped", 32'h3c, bsr_out);
    i_jtp_probe_model.scan(1'b0, 8, 32'ha5, d);
    chk("ir_stopped", 32'ha5, d[7:0]);
  endtask

  task automatic t_bypass();
    i_jtp_probe_model.scan(1'b1, 4, 32'h7, d);
    i_jtp_probe_model.scan(1'b0, 4, 32'hb, d);
    chk("bypass_unimpl", 32'h6, d[3:0]);
  endtask

  task automatic t_ext_int();
    for (int k = 0; k < 2; k++)
    begin
      i_jtp_probe_model.scan(1'b1, 4, (k == 0) ? 32'(jtp_pkg::IR_CODE_EXTEST)
                                             : 32'(jtp_pkg::IR_CODE_INTEST), d);
      @(negedge clock);
      bsr_in = 8'h0f;
      repeat (4) @(negedge clock);
      chk("extest_flag", 32'(k == 0), ext_act);
      chk("intest_flag", 32'(k == 1), int_act);
      i_jtp_probe_model.scan(1'b0, 4, 32'hb, d);
      chk("ext_int_path", 32'h6, d[3:0]);
      chk("ext_int_bsr", 32'ha5, bsr_out);
    end
  endtask

  task automatic t_tms_reset();
    i_jtp_probe_model.tck_bit(1'b1, 1'b1, q);
    i_jtp_probe_model.tck_bit(1'b0, 1'b1, q);
    i_jtp_probe_model.tck_bit(1'b0, 1'b1, q);
    repeat (5) i_jtp_probe_model.tck_bit(1'b1, 1'b1, q);
    i_jtp_probe_model.tck_bit(1'b0, 1'b1, q);
    read_id("idcode_tms");
    repeat (4) @(negedge clock);
    chk("intest_cleared", 32'h0, int_act);
  endtask

  task automatic t_hw_reset();
    for (int k = 0; k < 2; k++)
    begin
      i_jtp_probe_model.scan(1'b1, 4, 32'(jtp_pkg::IR_CODE_BYPASS), d);
      @(negedge clock);
      if (k == 0)
        trst_n = 1'b0;
      else
        rst = 1'b1;
      repeat (3) i_jtp_probe_model.tck_bit(1'b0, 1'b1, q);
      chk("oe_in_reset", 32'h0, tdo_oe);
      @(negedge clock);
      trst_n = 1'b1;
      rst = 1'b0;
      i_jtp_probe_model.tck_bit(1'b0, 1'b1, q);
      read_id((k == 0) ? "idcode_trst" : "idcode_por");
    end
  endtask

  task automatic t_afsel();
    logic [4:0] wd [3];
    logic [4:0] cm [3];
    logic [4:0] ex [3];
    wd = '{5'h00, 5'h00, 5'h1f};
    cm = '{5'h01, 5'h00, 5'h1f};
    ex = '{5'h1e, 5'h1e, 5'h1f};
    for (int k = 0; k < 3; k++)
    begin
      @(negedge clock);
      if (k > 0)
        chk("pin_select", 32'(ex[k-1]), pin_sel);
      afsel_write = 1'b1;
      afsel_wdata = wd[k];
      afsel_commit = cm[k];
    end
    @(negedge clock);
    afsel_write = 1'b0;
    chk("pin_select", 32'(ex[2]), pin_sel);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    err_total = 0;
    cmp_count = 0;
    rst = 1'b1;
    trst_n = 1'b1;
    bsr_in = 8'ha5;
    afsel_write = 1'b0;
    afsel_wdata = 5'h00;
    afsel_commit = 5'h00;
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_reset_state();
    t_sample();
    t_bypass();
    t_ext_int();
    t_tms_reset();
    t_hw_reset();
    t_afsel();
    close_out();
  end

  initial
  begin
    #200000;
    err_total++;
    close_out();
  end

endmodule // tb_jtp_tap_controller
